/* shared/csp_pkg.sv */
// Constants shared by both ends of the clock-synchronous serial link
// Notes on behaviour
// RULE1: Software sets mode nonzero before open-drain select.
// RULE2: Software clears open-drain select before mode zero.
// RULE3: External clock: request output low when ready.
// RULE4: Request output goes high once reception starts.
// RULE5: Request output inactive with internal clock.
// RULE6: Transmit starts on enable, data, clear-to-send.
// RULE7: External clock: last start condition while idle.
// RULE8: Polarity swaps shift-out and sample edges.
// RULE9: Only transmitter makes clock; dummy data shifts out.
// RULE10: Internal clock runs once enabled with data.
// RULE11: External receive needs enable, data, partner clock.
// RULE12: Frame into full buffer sets overrun flag.
// RULE13: Repeated overrun leaves request flag unchanged.
// RULE14: Software writes one dummy byte per frame.
// RULE15: Receive starts on both enables plus data.
// RULE16: Shift-empty flag reads 1 when register empty.
// RULE17: Buffer-full set on transfer, cleared on read.
package csp_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned CNT_W        = 3;
    localparam logic [2:0]  FRAME_LAST   = 3'h7;
    localparam logic [2:0]  MODE_OFF     = 3'h0;
    localparam logic [7:0]  DUMMY_BYTE   = 8'hFF;
    localparam int unsigned LINK_PER_NS  = 15;
    localparam int unsigned REF_PER_NS   = 40;
    localparam int unsigned DEV_HALF_NS  = 180;
    localparam int unsigned PRT_HALF_NS  = 200;
    localparam int unsigned DEV_HALF_CYC = (DEV_HALF_NS + LINK_PER_NS - 1) / LINK_PER_NS;
    localparam int unsigned PRT_HALF_CYC = (PRT_HALF_NS + REF_PER_NS - 1) / REF_PER_NS;
    localparam int unsigned DIV_W        = 4;
    localparam logic [3:0]  DEV_HALF_MAX = DIV_W'(DEV_HALF_CYC - 1);
    localparam logic [3:0]  PRT_HALF_MAX = DIV_W'(PRT_HALF_CYC - 1);
endpackage

/* shared/csp_if.sv */
// Pin-level carrier between the serial channel and its partner
`timescale 1ns/10ps
interface csp_if;
    logic sck_dev_o;
    logic sck_dev_oe;
    logic sck_prt_o;
    logic sck_prt_oe;
    logic sck;
    logic txd;
    logic rxd;
    logic rts_n;
    logic cts_n;

    // Wire level with a pull-up when nobody drives
    assign sck = sck_dev_oe ? sck_dev_o : (sck_prt_oe ? sck_prt_o : 1'b1);

    modport dev (input sck, rxd, cts_n, output sck_dev_o, sck_dev_oe, txd, rts_n);
    modport prt (input sck, txd, rts_n, output sck_prt_o, sck_prt_oe, rxd, cts_n);
endinterface

/* core/csp_buf2.sv */
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module csp_buf2 #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    logic [W-1:0] mem_r [2];
    logic         wp_r;
    logic         rp_r;
    logic [1:0]   cnt_r;
    logic         push;
    logic         pop;

    assign in_ready_out  = (cnt_r != 2'h2);
    assign out_valid_out = (cnt_r != 2'h0);
    assign out_data_out  = mem_r[rp_r];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* core/csp_device.sv */
// Serial channel end: register side on ref clock, shifter on link clock
`timescale 1ns/10ps
module csp_device (
    input  wire logic       ref_clk_in,
    input  wire logic       link_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [2:0] serial_mode_select_in,
    input  wire logic       clock_open_drain_sel_in,
    input  wire logic       clock_polarity_sel_in,
    input  wire logic       int_clk_sel_in,
    input  wire logic       rts_func_en_in,
    input  wire logic       cts_func_en_in,
    input  wire logic       transmit_enable_bit_in,
    input  wire logic       receive_enable_bit_in,
    input  wire logic       tx_wr_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       rx_rd_in,
    input  wire logic       irq_clr_in,
    output logic            tx_buffer_empty_flag_out,
    output logic            tx_shift_empty_flag_out,
    output logic [7:0]      receive_buffer_out,
    output logic            rx_buffer_full_flag_out,
    output logic            overrun_error_flag_out,
    output logic            irq_request_flag_out,
    csp_if.dev              lnk
);
    // Ref domain state
    logic [7:0] tb_r;
    logic       req_r;
    logic       ack_s1_r;
    logic       ack_s_r;
    logic       done_s1_r;
    logic       done_s_r;
    logic       done_d_r;
    logic       txe_s1_r;
    logic       txe_s_r;
    logic [7:0] rb_r;
    logic       full_r;
    logic       oer_r;
    logic       irq_r;
    logic       done_ev;

    // Link domain state
    logic [7:0] ctl_s1_r;
    logic [7:0] ctl_s_r;
    logic       sck_s1_r;
    logic       sck_s_r;
    logic       rxd_s1_r;
    logic       rxd_s_r;
    logic       cts_s1_r;
    logic       cts_s_r;
    logic       req_s1_r;
    logic       req_s_r;
    logic       full_s1_r;
    logic       full_s_r;
    logic       ack_r;
    logic       busy_r;
    logic       shifting_r;
    logic       rx_on_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_hold_r;
    logic       done_tgl_r;
    logic       gen_lvl_r;
    logic [3:0] div_r;
    logic       lvl_prev_r;
    logic       txd_r;
    logic       rts_n_r;
    logic       sck_o_r;
    logic       sck_oe_r;
    logic       en;
    logic       ods;
    logic       pol;
    logic       intc;
    logic       rtsen;
    logic       ctsen;
    logic       te;
    logic       re;
    logic       lvl_now;
    logic       fall;
    logic       rise;
    logic       pending;
    logic       start;
    logic       pin_lvl;

    // Ref domain: transmit buffer handed over by a toggle pair
    assign tx_buffer_empty_flag_out = (req_r == ack_s_r);
    assign tx_shift_empty_flag_out  = txe_s_r;
    assign receive_buffer_out       = rb_r;
    assign rx_buffer_full_flag_out  = full_r;
    assign overrun_error_flag_out   = oer_r;
    assign irq_request_flag_out     = irq_r;
    assign done_ev                  = done_s_r ^ done_d_r;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_s1_r  <= 1'b0;
            ack_s_r   <= 1'b0;
            done_s1_r <= 1'b0;
            done_s_r  <= 1'b0;
            done_d_r  <= 1'b0;
            txe_s1_r  <= 1'b1;
            txe_s_r   <= 1'b1;
        end else begin
            ack_s1_r  <= ack_r;
            ack_s_r   <= ack_s1_r;
            done_s1_r <= done_tgl_r;
            done_s_r  <= done_s1_r;
            done_d_r  <= done_s_r;
            txe_s1_r  <= ~busy_r;
            txe_s_r   <= txe_s1_r; // RULE16
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tb_r  <= 8'h00;
            req_r <= 1'b0;
        end else if (tx_wr_in && tx_buffer_empty_flag_out) begin
            tb_r  <= tx_data_in; // RULE14
            req_r <= ~req_r;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rb_r   <= 8'h00;
            full_r <= 1'b0;
        end else if (done_ev) begin
            rb_r   <= rx_hold_r;
            full_r <= 1'b1; // RULE17
        end else if (rx_rd_in) begin
            full_r <= 1'b0; // RULE17
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            oer_r <= 1'b0;
        end else if (done_ev && full_r) begin
            oer_r <= 1'b1; // RULE12
        end else if (serial_mode_select_in == csp_pkg::MODE_OFF || !receive_enable_bit_in) begin
            oer_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_r <= 1'b0;
        end else if (done_ev && !oer_r) begin
            irq_r <= 1'b1; // RULE13
        end else if (irq_clr_in) begin
            irq_r <= 1'b0;
        end
    end

    // Link domain: synchronisers for controls, pins and handshakes
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_s1_r  <= 8'h00;
            ctl_s_r   <= 8'h00;
            sck_s1_r  <= 1'b1;
            sck_s_r   <= 1'b1;
            rxd_s1_r  <= 1'b1;
            rxd_s_r   <= 1'b1;
            cts_s1_r  <= 1'b1;
            cts_s_r   <= 1'b1;
            req_s1_r  <= 1'b0;
            req_s_r   <= 1'b0;
            full_s1_r <= 1'b0;
            full_s_r  <= 1'b0;
        end else begin
            ctl_s1_r  <= {serial_mode_select_in != csp_pkg::MODE_OFF, clock_open_drain_sel_in,
                          clock_polarity_sel_in, int_clk_sel_in, rts_func_en_in, cts_func_en_in,
                          transmit_enable_bit_in, receive_enable_bit_in};
            ctl_s_r   <= ctl_s1_r;
            sck_s1_r  <= lnk.sck;
            sck_s_r   <= sck_s1_r;
            rxd_s1_r  <= lnk.rxd;
            rxd_s_r   <= rxd_s1_r;
            cts_s1_r  <= lnk.cts_n;
            cts_s_r   <= cts_s1_r;
            req_s1_r  <= req_r;
            req_s_r   <= req_s1_r;
            full_s1_r <= full_r;
            full_s_r  <= full_s1_r;
        end
    end

    assign {en, ods, pol, intc, rtsen, ctsen, te, re} = ctl_s_r;
    // Level normalised so that 1 is idle and 1->0 is the shift-out edge
    assign lvl_now = intc ? gen_lvl_r : (sck_s_r ^ pol); // RULE8
    assign fall    = lvl_prev_r & ~lvl_now;
    assign rise    = ~lvl_prev_r & lvl_now;
    assign pending = (req_s_r != ack_r);
    assign start   = en & pending & te & (~ctsen | ~cts_s_r) & ~busy_r // RULE6 RULE15
                     & (intc | lvl_now); // RULE7
    assign pin_lvl = gen_lvl_r ^ pol;

    // Internal shift clock generator
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gen_lvl_r  <= 1'b1;
            div_r      <= 4'h0;
            lvl_prev_r <= 1'b1;
        end else begin
            lvl_prev_r <= lvl_now;
            if (!busy_r || !intc) begin
                div_r     <= 4'h0;
                gen_lvl_r <= ~(start & intc); // RULE10
            end else if (div_r == csp_pkg::DEV_HALF_MAX) begin
                div_r     <= 4'h0;
                gen_lvl_r <= ~gen_lvl_r;
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // Shift engine: transmitter always runs, receiver rides along
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_r      <= 1'b0;
            busy_r     <= 1'b0;
            shifting_r <= 1'b0;
            rx_on_r    <= 1'b0;
            bit_cnt_r  <= 3'h0;
            tx_sh_r    <= 8'h00;
            rx_sh_r    <= 8'h00;
            rx_hold_r  <= 8'h00;
            done_tgl_r <= 1'b0;
            txd_r      <= 1'b1;
        end else if (!en) begin
            busy_r     <= 1'b0;
            shifting_r <= 1'b0;
            txd_r      <= 1'b1;
        end else if (start) begin
            busy_r    <= 1'b1; // RULE9 RULE11
            ack_r     <= req_s_r;
            tx_sh_r   <= tb_r;
            rx_on_r   <= re; // RULE15
            bit_cnt_r <= 3'h0;
        end else if (busy_r && fall) begin
            shifting_r <= 1'b1;
            txd_r      <= tx_sh_r[0]; // RULE8 RULE9
            tx_sh_r    <= {1'b1, tx_sh_r[7:1]};
        end else if (shifting_r && rise) begin
            rx_sh_r   <= {rxd_s_r, rx_sh_r[7:1]}; // RULE8
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == csp_pkg::FRAME_LAST) begin
                busy_r     <= 1'b0;
                shifting_r <= 1'b0;
                if (rx_on_r) begin
                    rx_hold_r  <= {rxd_s_r, rx_sh_r[7:1]};
                    done_tgl_r <= ~done_tgl_r;
                end
            end
        end
    end

    // Pin drivers: clock request and shift clock
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rts_n_r  <= 1'b1;
            sck_o_r  <= 1'b1;
            sck_oe_r <= 1'b0;
        end else begin
            rts_n_r  <= ~(en & rtsen & ~intc & re & busy_r & ~shifting_r & ~full_s_r); // RULE3 RULE4 RULE5
            sck_o_r  <= ods ? 1'b0 : pin_lvl;
            sck_oe_r <= en & intc & (~ods | ~pin_lvl);
        end
    end

    assign lnk.txd        = txd_r;
    assign lnk.rts_n      = rts_n_r;
    assign lnk.sck_dev_o  = sck_o_r;
    assign lnk.sck_dev_oe = sck_oe_r;
endmodule

/* core/csp_partner.sv */
// External serial partner: clock master or slave, buffered receive
`timescale 1ns/10ps
module csp_partner (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       make_clock_in,
    input  wire logic       clock_polarity_sel_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    input  wire logic       rx_ready_in,
    csp_if.prt              lnk
);
    logic       sck_s1_r;
    logic       sck_s_r;
    logic       txd_s1_r;
    logic       txd_s_r;
    logic       rts_s1_r;
    logic       rts_s_r;
    logic [7:0] hold_r;
    logic       hold_v_r;
    logic       busy_r;
    logic       run_r;
    logic       gen_lvl_r;
    logic [3:0] div_r;
    logic       lvl_prev_r;
    logic [2:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] rsh_r;
    logic       rxd_r;
    logic       push_r;
    logic [7:0] push_d_r;
    logic       cts_n_r;
    logic       buf_rdy;
    logic       lvl_now;
    logic       fall;
    logic       rise;
    logic       go;
    logic       raw_now;

    assign tx_ready_out = ~hold_v_r;
    // Edges come from the raw pin level, so in slave mode a polarity change alone is no edge
    assign raw_now      = make_clock_in ? (gen_lvl_r ^ clock_polarity_sel_in) : sck_s_r;
    assign lvl_now      = raw_now ^ clock_polarity_sel_in;
    assign fall         = (lvl_prev_r ^ clock_polarity_sel_in) & ~lvl_now;
    assign rise         = ~(lvl_prev_r ^ clock_polarity_sel_in) & lvl_now;
    assign go           = make_clock_in & ~run_r & ~rts_s_r & buf_rdy; // RULE11

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_s1_r <= 1'b1;
            sck_s_r  <= 1'b1;
            txd_s1_r <= 1'b1;
            txd_s_r  <= 1'b1;
            rts_s1_r <= 1'b1;
            rts_s_r  <= 1'b1;
        end else begin
            sck_s1_r <= lnk.sck;
            sck_s_r  <= sck_s1_r;
            txd_s1_r <= lnk.txd;
            txd_s_r  <= txd_s1_r;
            rts_s1_r <= lnk.rts_n;
            rts_s_r  <= rts_s1_r;
        end
    end

    // Clock generator when this end makes the shift clock
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_r      <= 1'b0;
            gen_lvl_r  <= 1'b1;
            div_r      <= 4'h0;
            lvl_prev_r <= 1'b1;
        end else begin
            lvl_prev_r <= raw_now;
            if (go) begin
                run_r     <= 1'b1;
                gen_lvl_r <= 1'b0;
                div_r     <= 4'h0;
            end else if (!run_r || (!busy_r && gen_lvl_r)) begin
                run_r     <= 1'b0;
                gen_lvl_r <= 1'b1;
            end else if (div_r == csp_pkg::PRT_HALF_MAX) begin
                div_r     <= 4'h0;
                gen_lvl_r <= ~gen_lvl_r;
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // Shifter: drive on shift-out edge, sample on the other
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hold_r   <= 8'h00;
            hold_v_r <= 1'b0;
            busy_r   <= 1'b0;
            cnt_r    <= 3'h0;
            sh_r     <= 8'h00;
            rsh_r    <= 8'h00;
            rxd_r    <= 1'b1;
            push_r   <= 1'b0;
            push_d_r <= 8'h00;
        end else begin
            push_r <= 1'b0;
            if (tx_valid_in && !hold_v_r) begin
                hold_r   <= tx_data_in;
                hold_v_r <= 1'b1;
            end
            if (fall && !busy_r) begin
                busy_r   <= 1'b1;
                cnt_r    <= 3'h0;
                rxd_r    <= hold_v_r ? hold_r[0] : 1'b1;
                sh_r     <= hold_v_r ? {1'b1, hold_r[7:1]} : csp_pkg::DUMMY_BYTE;
                if (hold_v_r) begin
                    hold_v_r <= 1'b0;
                end
            end else if (fall) begin
                rxd_r <= sh_r[0];
                sh_r  <= {1'b1, sh_r[7:1]};
            end else if (rise && busy_r) begin
                rsh_r <= {txd_s_r, rsh_r[7:1]};
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r == csp_pkg::FRAME_LAST) begin
                    busy_r   <= 1'b0;
                    push_r   <= 1'b1;
                    push_d_r <= {txd_s_r, rsh_r[7:1]};
                end
            end
        end
    end

    // Full buffer raises clear-to-send so the channel holds off
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cts_n_r <= 1'b1;
        end else begin
            cts_n_r <= ~buf_rdy | busy_r; // RULE6
        end
    end

    csp_buf2 #(.W(csp_pkg::DATA_W)) u_rx_buf (
        .clk_in        (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push_r),
        .in_ready_out  (buf_rdy),
        .in_data_in    (push_d_r),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (rx_data_out)
    );

    assign lnk.rxd        = rxd_r;
    assign lnk.cts_n      = cts_n_r;
    assign lnk.sck_prt_o  = gen_lvl_r ^ clock_polarity_sel_in;
    assign lnk.sck_prt_oe = make_clock_in;
endmodule

/* verification/csp_properties.sv */
// Wire-level assertions on the serial link
`timescale 1ns/10ps
module csp_properties (
    input wire logic link_clk_in,
    input wire logic rst_b_in,
    input wire logic sck_dev_oe,
    input wire logic sck_prt_oe,
    input wire logic sck,
    input wire logic txd,
    input wire logic rts_n,
    input wire logic cts_n
);
    logic       sck_q_r;
    logic [3:0] quiet_r;

    default clocking @(posedge link_clk_in); endclocking
    default disable iff (!rst_b_in);

    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) sck_q_r <= 1'h1;
        else sck_q_r <= sck;
    end

    // Cycles since the shift clock last moved
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) quiet_r <= 4'hF;
        else if (sck != sck_q_r) quiet_r <= 4'h0;
        else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end

    dual_drive_a: assert property (!(sck_dev_oe && sck_prt_oe))
        else $error("both ends drive the shift clock");
    rts_int_a: assert property (sck_dev_oe |-> rts_n)
        else $error("request low while device makes the clock");
    rts_fast_a: assert property (sck_prt_oe && $changed(sck) && !rts_n |-> ##[0:8] rts_n)
        else $error("request still low after reception began");
    rts_cause_a: assert property ($rose(rts_n) && sck_prt_oe |-> quiet_r < 4'h8)
        else $error("request rose without clock activity");
    dev_half_a: assert property (!sck_prt_oe && !$past(sck_prt_oe) && $changed(sck) |=> $stable(sck)[*3])
        else $error("device clock half period too short");
    prt_half_a: assert property (sck_prt_oe && $past(sck_prt_oe) && $changed(sck) |=> $stable(sck)[*8])
        else $error("partner clock half period too short");
    cts_busy_a: assert property (sck_dev_oe && $past(sck_dev_oe) && $changed(sck) |-> ##[0:12] cts_n)
        else $error("clear to send low during a frame");
    txd_hold_a: assert property (!sck_prt_oe && $changed(txd) |=> $stable(txd)[*3])
        else $error("data changed within a clock half");
endmodule

/* verification/test_clock_sync_serial_port.sv */
// Self-checking bench for the serial channel and its partner
`timescale 1ns/10ps
module test_clock_sync_serial_port;
    logic        ref_clk_in, link_clk_in, rst_b_in, od, pol, ick, rtse, ctse, te, re, wr, rd, iclr;
    logic        mk, pv, rr, tbe, tse, full, overrun_error_flag, irq, prdy, rv;
    logic [2:0]  mode;
    logic [7:0]  wd, pd, rb, rdat, a, d;
    logic [31:0] seed_r = 32'h00003868;
    int          n_errors = 0;
    int          num_checks = 0;

    csp_if lnk ();
    csp_device csp_device_inst (.ref_clk_in(ref_clk_in), .link_clk_in(link_clk_in), .rst_b_in(rst_b_in),
        .serial_mode_select_in(mode), .clock_open_drain_sel_in(od), .clock_polarity_sel_in(pol),
        .int_clk_sel_in(ick), .rts_func_en_in(rtse), .cts_func_en_in(ctse), .transmit_enable_bit_in(te),
        .receive_enable_bit_in(re), .tx_wr_in(wr), .tx_data_in(wd), .rx_rd_in(rd), .irq_clr_in(iclr),
        .tx_buffer_empty_flag_out(tbe), .tx_shift_empty_flag_out(tse), .receive_buffer_out(rb),
        .rx_buffer_full_flag_out(full), .overrun_error_flag_out(overrun_error_flag), .irq_request_flag_out(irq), .lnk(lnk));
    csp_partner csp_partner_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .make_clock_in(mk),
        .clock_polarity_sel_in(pol), .tx_valid_in(pv), .tx_data_in(pd), .tx_ready_out(prdy),
        .rx_valid_out(rv), .rx_data_out(rdat), .rx_ready_in(rr), .lnk(lnk));
    csp_properties csp_properties_inst (.link_clk_in(link_clk_in), .rst_b_in(rst_b_in),
        .sck_dev_oe(lnk.sck_dev_oe), .sck_prt_oe(lnk.sck_prt_oe), .sck(lnk.sck), .txd(lnk.txd),
        .rts_n(lnk.rts_n), .cts_n(lnk.cts_n));

    function automatic logic [7:0] rnd();
        seed_r ^= seed_r << 13;
        seed_r ^= seed_r >> 17;
        seed_r ^= seed_r << 5;
        return seed_r[7:0];
    endfunction

    // A pending overrun keeps a cleared request cleared
    function automatic logic [7:0] irq_exp(input int f);
        return 8'(f < 2);
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic await(input string nm, ref logic s, input logic v);
        for (int i = 0; i < 800 && s !== v; i++) @(posedge ref_clk_in);
        chk(nm, 8'(s), 8'(v));
    endtask

    task automatic pulse(input logic clr);
        @(posedge ref_clk_in);
        if (clr) iclr <= 1'h1;
        else rd <= 1'h1;
        @(posedge ref_clk_in);
        iclr <= 1'h0;
        rd <= 1'h0;
    endtask

    task automatic pput(input logic [7:0] v);
        @(posedge ref_clk_in);
        pv <= 1'h1;
        pd <= v;
        @(posedge ref_clk_in);
        await("partner ready", prdy, 1'h1);
        pv <= 1'h0;
    endtask

    task automatic pget(input logic [7:0] v);
        await("partner valid", rv, 1'h1);
        rr <= 1'h1;
        @(posedge ref_clk_in);
        chk("partner byte", rdat, v);
        rr <= 1'h0;
    endtask

    task automatic write(input logic [7:0] v);
        @(posedge ref_clk_in);
        wr <= 1'h1;
        wd <= v;
        @(posedge ref_clk_in);
        wr <= 1'h0;
        @(posedge ref_clk_in);
        chk("tx empty", 8'(tbe), 8'h00);
    endtask

    task automatic finish();
        await("shift busy", tse, 1'h0);
        await("shift done", tse, 1'h1);
        tick(8);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'h0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        link_clk_in = 1'h0;
        #3.3;
        forever #7.5 link_clk_in = ~link_clk_in;
    end

    initial begin
        tick(60000);
        n_errors++;
        wrap_up();
    end

    initial begin
        {rst_b_in, od, pol, ick, rtse, ctse, te, re, wr, rd, iclr, mk, pv, rr} = '0;
        {mode, wd, pd} = '0;
        tick(20);
        rst_b_in <= 1'h1;
        tick(4);
        ick <= 1'h1;
        te <= 1'h1;
        re <= 1'h1;
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            tick(6);
            mode <= 3'h1;
            tick(6);
            od <= p[0];
            tick(6);
            for (int f = 0; f < 3; f++) begin
                a = rnd();
                d = rnd();
                pput(a);
                write(d);
                finish();
                if (f == 0) chk("rx byte", rb, a);
                chk("rx full", 8'(full), 8'h01);
                chk("overrun", 8'(overrun_error_flag), 8'(f > 0));
                chk("irq", 8'(irq), irq_exp(f));
                pget(d);
                pulse(1'h1);
            end
            pulse(1'h0);
            tick(3);
            chk("rx full", 8'(full), 8'h00);
            pol <= 1'h0;
            tick(6);
            od <= 1'h0;
            tick(6);
            mode <= 3'h0;
            tick(6);
            $display("internal clock polarity %0d done", p);
        end
        mode <= 3'h1;
        re <= 1'h0;
        te <= 1'h0;
        ctse <= 1'h1;
        tick(6);
        d = rnd();
        write(d);
        tick(100);
        chk("tx held", 8'(tbe), 8'h00);
        chk("shift idle", 8'(tse), 8'h01);
        te <= 1'h1;
        finish();
        chk("rx full", 8'(full), 8'h00);
        pget(d);
        $display("enable gating done");
        mode <= 3'h0;
        tick(6);
        {ick, ctse, pol} <= '0;
        mk <= 1'h1;
        rtse <= 1'h1;
        re <= 1'h1;
        tick(6);
        mode <= 3'h1;
        tick(6);
        for (int k = 0; k < 2; k++) begin
            a = rnd();
            pput(a);
            chk("rts idle", 8'(lnk.rts_n), 8'h01);
            write(csp_pkg::DUMMY_BYTE);
            await("rts ready", lnk.rts_n, 1'h0);
            finish();
            chk("rx byte", rb, a);
            pget(csp_pkg::DUMMY_BYTE);
            pulse(1'h0);
        end
        $display("external clock done");
        wrap_up();
    end
endmodule
